// ---- src/drpcf_pkg.sv ----
package drpcf_pkg;

    localparam int NUM_BANKS = 4;
    localparam int ROW_W     = 12;
    localparam int CLK_MHZ   = 100;

    // device timing in ns, turned into system clock cycles (least times round up)
    localparam int T_RFC_NS  = 70;
    localparam int T_RP_NS   = 15;
    localparam int T_RCD_NS  = 15;
    localparam int T_REFI_NS = 7800;

    localparam logic [7:0] RFC_CYC  = 8'((T_RFC_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] RP_CYC   = 8'((T_RP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] RCD_CYC  = 8'((T_RCD_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] SREF_CYC = 10'(T_REFI_NS * CLK_MHZ / 1000);

    // counts of link clock edges
    localparam logic [7:0] XSR_EDGES   = 8'hC8;
    localparam logic [7:0] BURST_EDGES = 8'h02;

    localparam logic [7:0]       TMR_ZERO = 8'h00;
    localparam logic [7:0]       TMR_ONE  = 8'h01;
    localparam logic [ROW_W-1:0] ROW_RST  = 12'h000;

    typedef enum logic [3:0] {
        CMD_DESEL, CMD_NOP, CMD_ACT, CMD_REF, CMD_MRS, CMD_RD, CMD_WR, CMD_PRE, CMD_BST
    } drpcf_cmd_e;

    typedef enum logic [2:0] {
        MODE_NORMAL, MODE_PDN_PRE, MODE_PDN_ACT, MODE_SREF, MODE_XSR
    } drpcf_mode_e;

    typedef enum logic [2:0] {
        BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE, BK_READ_AP, BK_WRITE_AP, BK_PRECHG
    } drpcf_bank_e;

    typedef struct packed {
        logic       cs_n;
        logic       ras_n;
        logic       cas_n;
        logic       we_n;
        logic       cke;
        logic [1:0] ba;
        logic       a10;
    } drpcf_pins_s;

    typedef struct packed {
        logic       valid;
        logic       cke_prev;
        logic       cke;
        drpcf_cmd_e cmd;
        logic [1:0] ba;
        logic       a10;
    } drpcf_slot_s;

    typedef struct packed {
        drpcf_bank_e st;
        logic [7:0]  tmr;
    } drpcf_bank_s;

endpackage

// ---- src/drpcf_pin_sampler.sv ----
`timescale 1ns/100ps
module drpcf_pin_sampler
    import drpcf_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_arst_n,
    input  wire logic        i_ce,
    input  wire logic        i_ck,
    input  wire drpcf_pins_s i_pins,
    output drpcf_slot_s      o_slot
);

    typedef struct packed {
        drpcf_pins_s pins_m;
        drpcf_pins_s pins_s;
        logic        ck_m;
        logic        ck_s;
        logic        ck_p;
        logic        cke_p;
        drpcf_slot_s slot;
    } drpcf_smp_s;

    drpcf_smp_s s_q;
    drpcf_smp_s s_d;

    function automatic drpcf_cmd_e decode(input drpcf_pins_s p);
        drpcf_cmd_e c;
        c = CMD_DESEL;
        if (!p.cs_n)
        begin
            case ({p.ras_n, p.cas_n, p.we_n})
                3'h7:    c = CMD_NOP;
                3'h3:    c = CMD_ACT;
                3'h1:    c = CMD_REF;
                3'h0:    c = CMD_MRS;
                3'h5:    c = CMD_RD;
                3'h4:    c = CMD_WR;
                3'h2:    c = CMD_PRE;
                3'h6:    c = CMD_BST;
                default: c = CMD_DESEL;
            endcase
        end
        return c;
    endfunction

    always_comb
    begin
        s_d            = s_q;
        s_d.pins_m     = i_pins;
        s_d.pins_s     = s_q.pins_m;
        s_d.ck_m       = i_ck;
        s_d.ck_s       = s_q.ck_m;
        s_d.ck_p       = s_q.ck_s;
        s_d.slot.valid = 1'b0;
        // rising link clock edge registers the command
        if (s_q.ck_s && !s_q.ck_p)
        begin
            s_d.slot.valid    = 1'b1;
            s_d.slot.cke_prev = s_q.cke_p;
            s_d.slot.cke      = s_q.pins_s.cke;
            s_d.slot.cmd      = decode(s_q.pins_s);
            s_d.slot.ba       = s_q.pins_s.ba;
            s_d.slot.a10      = s_q.pins_s.a10;
            s_d.cke_p         = s_q.pins_s.cke;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            s_q <= '0;
        else if (i_ce)
            s_q <= s_d;
    end

    assign o_slot = s_q.slot;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n || !i_ce);

    property p_desel_decode;
        s_q.ck_s && !s_q.ck_p && s_q.pins_s.cs_n |=> o_slot.valid && o_slot.cmd == CMD_DESEL;
    endproperty
    a_desel_decode: assert property (p_desel_decode) else $error("deselect not decoded");

    property p_ref_decode;
        s_q.ck_s && !s_q.ck_p && !s_q.pins_s.cs_n && !s_q.pins_s.ras_n && !s_q.pins_s.cas_n
            && s_q.pins_s.we_n |=> o_slot.cmd == CMD_REF;
    endproperty
    a_ref_decode: assert property (p_ref_decode) else $error("auto refresh not decoded");

endmodule

// ---- src/drpcf_cmd_fsm.sv ----
`timescale 1ns/100ps
module drpcf_cmd_fsm
    import drpcf_pkg::*;
(
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_arst_n,
    input  wire logic                    i_ce,
    input  wire logic                    i_ck,
    input  wire drpcf_pins_s             i_pins,
    output drpcf_mode_e                  o_mode,
    output drpcf_bank_e [NUM_BANKS-1:0]  o_bank_state,
    output logic [ROW_W-1:0]             o_refresh_row,
    output logic                         o_refresh_busy,
    output logic                         o_illegal,
    output logic                         o_int_clk_en,
    output logic                         o_buf_en
);

    typedef struct packed {
        drpcf_mode_e                 mode;
        drpcf_bank_s [NUM_BANKS-1:0] banks;
        logic [7:0]                  ref_tmr;
        logic                        ref_busy;
        logic [7:0]                  xsr_cnt;
        logic [9:0]                  sref_tmr;
        logic [ROW_W-1:0]            row;
        logic [1:0]                  last_rd;
        logic                        illegal;
        logic                        int_clk_en;
        logic                        buf_en;
    } drpcf_state_s;

    drpcf_state_s s_q;
    drpcf_state_s s_d;
    drpcf_slot_s  slot;
    drpcf_bank_s  bank_d [NUM_BANKS];
    drpcf_bank_e  tgt_st;
    logic         all_idle;
    logic         any_ap;
    logic         pre_all_ok;
    logic         is_nop;
    logic         cmd_ok;
    logic         exec;

    drpcf_pin_sampler u_sampler (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_ce      (i_ce),
        .i_ck      (i_ck),
        .i_pins    (i_pins),
        .o_slot    (slot)
    );

    // legality of the registered command against bank states
    always_comb
    begin
        all_idle   = 1'b1;
        any_ap     = 1'b0;
        pre_all_ok = 1'b1;
        for (int i = 0; i < NUM_BANKS; i++)
        begin
            all_idle   = all_idle & (s_q.banks[i].st == BK_IDLE);
            any_ap     = any_ap | (s_q.banks[i].st inside {BK_READ_AP, BK_WRITE_AP});
            pre_all_ok = pre_all_ok & !(s_q.banks[i].st inside {BK_ACTIVATING, BK_READ_AP, BK_WRITE_AP});
        end
        tgt_st = s_q.banks[slot.ba].st;
        is_nop = slot.cmd inside {CMD_DESEL, CMD_NOP};
        case (slot.cmd)
            CMD_DESEL, CMD_NOP: cmd_ok = 1'b1;
            CMD_ACT:            cmd_ok = tgt_st == BK_IDLE;
            CMD_RD:             cmd_ok = (tgt_st inside {BK_ACTIVE, BK_READ, BK_WRITE}) && !any_ap;
            CMD_WR:             cmd_ok = (tgt_st inside {BK_ACTIVE, BK_WRITE}) && !any_ap;
            CMD_PRE:            cmd_ok = slot.a10 ? pre_all_ok
                                         : !(tgt_st inside {BK_ACTIVATING, BK_READ_AP, BK_WRITE_AP});
            CMD_REF, CMD_MRS:   cmd_ok = all_idle;
            CMD_BST:            cmd_ok = s_q.banks[s_q.last_rd].st == BK_READ;
            default:            cmd_ok = 1'b0;
        endcase
        if (s_q.ref_busy && !is_nop)
            cmd_ok = 1'b0;
        exec = slot.valid && (s_q.mode == MODE_NORMAL) && slot.cke_prev && slot.cke && cmd_ok;
    end

    for (genvar g = 0; g < NUM_BANKS; g++)
    begin : g_bank
        drpcf_bank_s nb;
        logic        tgt;
        logic        bursting;

        always_comb
        begin
            nb       = s_q.banks[g];
            tgt      = slot.ba == 2'(g);
            bursting = nb.st inside {BK_READ, BK_WRITE, BK_READ_AP, BK_WRITE_AP};
            if (nb.tmr != TMR_ZERO && (!bursting || slot.valid))
                nb.tmr = nb.tmr - TMR_ONE;
            if (nb.tmr == TMR_ZERO)
            begin
                case (nb.st)
                    BK_ACTIVATING, BK_READ, BK_WRITE: nb.st = BK_ACTIVE;
                    BK_PRECHG:                        nb.st = BK_IDLE;
                    BK_READ_AP, BK_WRITE_AP:
                    begin
                        nb.st  = BK_PRECHG;
                        nb.tmr = RP_CYC;
                    end
                    default:                          nb.st = nb.st;
                endcase
            end
            if (exec)
            begin
                case (slot.cmd)
                    CMD_ACT:
                    if (tgt)
                    begin
                        nb.st  = BK_ACTIVATING;
                        nb.tmr = RCD_CYC;
                    end
                    // new bursts replace the running one
                    CMD_RD, CMD_WR:
                    if (tgt)
                    begin
                        nb.st  = (slot.cmd == CMD_RD) ? (slot.a10 ? BK_READ_AP : BK_READ)
                                 : (slot.a10 ? BK_WRITE_AP : BK_WRITE);
                        nb.tmr = BURST_EDGES;
                    end
                    CMD_PRE:
                    if ((tgt || slot.a10) && s_q.banks[g].st != BK_IDLE)
                    begin
                        nb.st  = BK_PRECHG;
                        nb.tmr = RP_CYC;
                    end
                    CMD_BST:
                    if (s_q.last_rd == 2'(g))
                    begin
                        nb.st  = BK_ACTIVE;
                        nb.tmr = TMR_ZERO;
                    end
                    default: nb.st = nb.st;
                endcase
            end
        end

        assign bank_d[g] = nb;
    end

    always_comb
    begin
        s_d         = s_q;
        s_d.illegal = 1'b0;
        for (int i = 0; i < NUM_BANKS; i++)
            s_d.banks[i] = bank_d[i];
        if (s_q.ref_tmr != TMR_ZERO)
            s_d.ref_tmr = s_q.ref_tmr - TMR_ONE;
        // internal row counter advances per refresh
        if (exec && slot.cmd == CMD_REF)
        begin
            s_d.row     = s_q.row + ROW_W'(1);
            s_d.ref_tmr = RFC_CYC;
        end
        if (exec && slot.cmd == CMD_RD)
            s_d.last_rd = slot.ba;
        // self refresh timed without the link clock
        if (s_q.mode == MODE_SREF)
        begin
            if (s_q.sref_tmr == 10'h000)
            begin
                s_d.row      = s_q.row + ROW_W'(1);
                s_d.sref_tmr = SREF_CYC;
            end
            else
                s_d.sref_tmr = s_q.sref_tmr - 10'h001;
        end
        if (slot.valid)
        begin
            case (s_q.mode)
                MODE_NORMAL:
                if (slot.cke_prev && !slot.cke)
                begin
                    if (slot.cmd == CMD_REF && all_idle && !s_q.ref_busy)
                    begin
                        s_d.mode     = MODE_SREF;
                        s_d.sref_tmr = SREF_CYC;
                    end
                    else if (is_nop)
                        s_d.mode = all_idle ? MODE_PDN_PRE : MODE_PDN_ACT;
                    else
                        s_d.illegal = 1'b1;
                end
                else
                    s_d.illegal = slot.cke_prev ? !cmd_ok : !is_nop;
                MODE_PDN_PRE, MODE_PDN_ACT:
                if (slot.cke)
                begin
                    s_d.mode    = MODE_NORMAL;
                    s_d.illegal = !is_nop;
                end
                MODE_SREF:
                if (slot.cke)
                begin
                    s_d.mode    = MODE_XSR;
                    s_d.xsr_cnt = XSR_EDGES;
                    s_d.illegal = !is_nop;
                end
                MODE_XSR:
                begin
                    s_d.illegal = !is_nop;
                    s_d.xsr_cnt = s_q.xsr_cnt - TMR_ONE;
                    if (s_q.xsr_cnt <= TMR_ONE)
                        s_d.mode = MODE_NORMAL;
                end
                default: s_d.mode = MODE_NORMAL;
            endcase
        end
        s_d.ref_busy   = s_d.ref_tmr != TMR_ZERO;
        s_d.int_clk_en = s_d.mode != MODE_SREF;
        s_d.buf_en     = !(s_d.mode inside {MODE_PDN_PRE, MODE_PDN_ACT, MODE_SREF});
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            s_q            <= '0;
            s_q.row        <= ROW_RST;
            s_q.int_clk_en <= 1'b1;
            s_q.buf_en     <= 1'b1;
        end
        else if (i_ce)
            s_q <= s_d;
    end

    always_comb
    begin
        for (int i = 0; i < NUM_BANKS; i++)
            o_bank_state[i] = s_q.banks[i].st;
    end

    assign o_mode         = s_q.mode;
    assign o_refresh_row  = s_q.row;
    assign o_refresh_busy = s_q.ref_busy;
    assign o_illegal      = s_q.illegal;
    assign o_int_clk_en   = s_q.int_clk_en;
    assign o_buf_en       = s_q.buf_en;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n || !i_ce);

    sequence s_ref_exec;
        exec && slot.cmd == CMD_REF;
    endsequence

    sequence s_cke_fall;
        slot.valid && o_mode == MODE_NORMAL && slot.cke_prev && !slot.cke;
    endsequence

    property p_ref_row;
        s_ref_exec |=> o_refresh_row == $past(o_refresh_row) + ROW_W'(1);
    endproperty
    a_ref_row: assert property (p_ref_row) else $error("refresh row not advanced");

    property p_ref_busy;
        s_ref_exec |=> o_refresh_busy [*7] ##1 !o_refresh_busy;
    endproperty
    a_ref_busy: assert property (p_ref_busy) else $error("refresh busy length wrong");

    property p_sref_entry;
        s_cke_fall ##0 (slot.cmd == CMD_REF && all_idle && !o_refresh_busy) |=> o_mode == MODE_SREF;
    endproperty
    a_sref_entry: assert property (p_sref_entry) else $error("self refresh not entered");

    property p_sref_hold;
        o_mode == MODE_SREF && !(slot.valid && slot.cke) |=> o_mode == MODE_SREF && !o_illegal;
    endproperty
    a_sref_hold: assert property (p_sref_hold) else $error("self refresh left without cke");

    property p_sref_clk;
        o_mode == MODE_SREF |-> !o_int_clk_en && !o_buf_en;
    endproperty
    a_sref_clk: assert property (p_sref_clk) else $error("clock not gated in self refresh");

    property p_pdn_entry;
        s_cke_fall ##0 (is_nop && all_idle) |=> o_mode == MODE_PDN_PRE ##0 !o_buf_en;
    endproperty
    a_pdn_entry: assert property (p_pdn_entry) else $error("precharge power-down not entered");

    property p_pdn_exit;
        (o_mode inside {MODE_PDN_PRE, MODE_PDN_ACT}) && slot.valid && slot.cke && is_nop
            |=> o_mode == MODE_NORMAL && o_buf_en && !o_illegal;
    endproperty
    a_pdn_exit: assert property (p_pdn_exit) else $error("power-down not exited");

    property p_bst_last;
        exec && slot.cmd == CMD_BST |=> o_bank_state[$past(s_q.last_rd)] == BK_ACTIVE;
    endproperty
    a_bst_last: assert property (p_bst_last) else $error("burst terminate missed read bank");

endmodule

// ---- verif/drpcf_ctrl_model.sv ----
`timescale 1ns/100ps
module drpcf_ctrl_model
    import drpcf_pkg::*;
(
    input  wire logic  i_clk_sys,
    output logic        o_ck,
    output drpcf_pins_s o_pins
);
    initial
    begin
        o_ck   = 1'b0;
        o_pins = 8'hF8;
    end

    // one command per link clock edge, pins stable half a period either side
    // caller picks only legal spacing unless refusal is meant
    task automatic send(input drpcf_pins_s p);
        o_pins = p;
        #62.5 o_ck = 1'b1;
        #62.5 o_ck = 1'b0;
    endtask

    // link clock stands still, as allowed while the device refreshes itself
    // clock stopped, restored before cke rises
    task automatic pause(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
endmodule

// ---- verif/tb_drpcf_cmd_fsm.sv ----
`timescale 1ns/100ps
module tb_drpcf_cmd_fsm
    import drpcf_pkg::*;
;
    typedef struct packed {
        logic                          full;
        logic                          ill;
        logic                          busy;
        drpcf_mode_e                   mode;
        drpcf_bank_e [NUM_BANKS-1:0]   bk;
        logic [ROW_W-1:0]              row;
    } drpcf_exp_s;

    logic                          clk;
    logic                          arst_n;
    logic                          ck;
    drpcf_pins_s                   pins;
    drpcf_mode_e                   o_mode;
    drpcf_bank_e [NUM_BANKS-1:0]   o_bank_state;
    logic [ROW_W-1:0]              o_refresh_row;
    logic                          o_refresh_busy;
    logic                          o_illegal;
    logic                          o_int_clk_en;
    logic                          o_buf_en;
    logic                          ill_seen = 1'b0;
    int                            fails    = 0;
    int                            checked  = 0;
    logic [31:0]                   seed     = 32'he80c_53ec;
    drpcf_exp_s                    exp_q[$];
    drpcf_mode_e                   e_mode;
    drpcf_bank_e [NUM_BANKS-1:0]   e_bk;
    logic [ROW_W-1:0]              e_row;

    drpcf_ctrl_model ctl (
        .i_clk_sys (clk),
        .o_ck      (ck),
        .o_pins    (pins)
    );

    drpcf_cmd_fsm DUT (
        .i_clk_sys      (clk),
        .i_arst_n       (arst_n),
        .i_ce           (1'b1),
        .i_ck           (ck),
        .i_pins         (pins),
        .o_mode         (o_mode),
        .o_bank_state   (o_bank_state),
        .o_refresh_row  (o_refresh_row),
        .o_refresh_busy (o_refresh_busy),
        .o_illegal      (o_illegal),
        .o_int_clk_en   (o_int_clk_en),
        .o_buf_en       (o_buf_en)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic drpcf_pins_s enc(input drpcf_cmd_e c, input logic [1:0] ba, input logic a10,
                                        input logic cke);
        logic [3:0] k;
        case (c)
            CMD_NOP: k = 4'h7;
            CMD_ACT: k = 4'h3;
            CMD_REF: k = 4'h1;
            CMD_MRS: k = 4'h0;
            CMD_RD:  k = 4'h5;
            CMD_WR:  k = 4'h4;
            CMD_PRE: k = 4'h2;
            CMD_BST: k = 4'h6;
            default: k = {1'b1, 3'(rnd())};
        endcase
        return {k, cke, ba, a10};
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic go(input drpcf_pins_s p, input logic ill, input logic full, input logic busy);
        exp_q.push_back('{full, ill, busy, e_mode, e_bk, e_row});
        ctl.send(p);
    endtask

    task automatic op(input drpcf_cmd_e c, input logic [1:0] ba, input logic a10, input logic cke,
                      input logic ill, input logic full);
        go(enc(c, ba, a10, cke), ill, full, (c == CMD_REF) && cke && !ill);
    endtask

    // random pins with cke held low
    task automatic junk();
        drpcf_pins_s p;
        p     = drpcf_pins_s'(8'(rnd()));
        p.cke = 1'b0;
        go(p, 1'b0, 1'b1, 1'b0);
    endtask

    always @(posedge clk)
        if (o_illegal === 1'b1)
            ill_seen = 1'b1;

    // result of each link edge is settled 90 ns after it
    initial
    forever
    begin
        drpcf_exp_s e;
        @(posedge ck);
        #90;
        if (exp_q.size() == 0)
            check(64'h0, 64'h1);
        else
        begin
            e = exp_q.pop_front();
            check(64'(ill_seen), 64'(e.ill));
            if (e.full)
            begin
                check(64'(o_mode), 64'(e.mode));
                check(64'(o_bank_state), 64'(e.bk));
                check(64'(o_refresh_row), 64'(e.row));
                check(64'(o_refresh_busy), 64'(e.busy));
                check(64'(o_buf_en), 64'(e.mode inside {MODE_NORMAL, MODE_XSR}));
                check(64'(o_int_clk_en), 64'(e.mode != MODE_SREF));
            end
        end
        ill_seen = 1'b0;
    end

    initial
    begin
        #200_000;
        fails = fails + 1;
        print_verdict();
    end

    initial
    begin
        arst_n = 1'b0;
        e_mode = MODE_NORMAL;
        e_bk   = '{default: BK_IDLE};
        e_row  = ROW_RST;
        repeat (12) @(posedge clk);
        #1 arst_n = 1'b1;
        op(CMD_NOP, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        e_row = e_row + 12'h001;
        op(CMD_REF, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        op(CMD_MRS, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        // activate after refresh, then refused repeats
        e_bk[0] = BK_ACTIVE;
        op(CMD_ACT, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        op(CMD_ACT, 2'h0, 1'b0, 1'b1, 1'b1, 1'b1);
        op(CMD_REF, 2'h0, 1'b0, 1'b1, 1'b1, 1'b1);
        e_bk[0] = BK_READ;
        op(CMD_RD, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        op(CMD_RD, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        e_bk[0] = BK_ACTIVE;
        op(CMD_BST, 2'h1, 1'b0, 1'b1, 1'b0, 1'b1);
        e_bk[0] = BK_WRITE;
        op(CMD_WR, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        op(CMD_WR, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        e_bk[0] = BK_READ;
        op(CMD_RD, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        e_bk[0] = BK_IDLE;
        op(CMD_PRE, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        e_bk[1] = BK_ACTIVE;
        op(CMD_ACT, 2'h1, 1'b0, 1'b1, 1'b0, 1'b1);
        e_mode = MODE_PDN_ACT;
        op(CMD_NOP, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
        junk();
        junk();
        e_mode = MODE_NORMAL;
        op(CMD_NOP, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        e_bk[1] = BK_IDLE;
        op(CMD_PRE, 2'h0, 1'b1, 1'b1, 1'b0, 1'b1);
        e_mode = MODE_PDN_PRE;
        op(CMD_DESEL, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
        e_mode = MODE_NORMAL;
        op(CMD_DESEL, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        // access period of auto-precharge read refuses another read
        e_bk[2] = BK_ACTIVE;
        op(CMD_ACT, 2'h2, 1'b0, 1'b1, 1'b0, 1'b1);
        e_bk[2] = BK_READ_AP;
        op(CMD_RD, 2'h2, 1'b1, 1'b1, 1'b0, 1'b1);
        op(CMD_RD, 2'h2, 1'b0, 1'b1, 1'b1, 1'b1);
        e_bk[2] = BK_IDLE;
        op(CMD_NOP, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        op(CMD_NOP, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        // self refresh entry, row moves only on the internal timer
        e_mode = MODE_SREF;
        op(CMD_REF, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
        // internal refresh goes on with the link clock stopped
        ctl.pause(2000);
        e_row = e_row + 12'h002;
        junk();
        junk();
        // exit, commands refused during the exit delay
        e_mode = MODE_XSR;
        op(CMD_NOP, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        op(CMD_ACT, 2'h3, 1'b0, 1'b1, 1'b1, 1'b1);
        repeat (198) op(CMD_NOP, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        e_mode = MODE_NORMAL;
        op(CMD_NOP, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        op(CMD_NOP, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        // refresh right after leaving self refresh, gap kept short
        e_row = e_row + 12'h001;
        op(CMD_REF, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        op(CMD_NOP, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        repeat (20) @(posedge clk);
        print_verdict();
    end
endmodule
